//--- core/cpr_regs.sv
// Codec power-down, extended capability and extended control registers.
// Operation
// - Ready bits ADC, DAC, analog and reference are read-only; writes ignored.
// - Each ready bit is 1 only while its subsection runs nominally.
// - Reference ready needs both the reference and bias pins settled.
// - Input path power-down stops ADCs; clearing it keeps reference on.
// - Output converter power-down stops DACs and EQ; clearing keeps reference on.
// - Mixer power-down acts only while the mixer qualifier is 0.
// - Bias power-down with mixer powered only turns off bias pins.
// - Link power-down stops the link; host finishes power-ups first.
// - Clock disable stops clocks only when converters and link are down.
// - External amp shutdown bit drives its pin high when set.
// - Capability register reads fixed feature ones as its reset value.
// - Link version field reads 10, codec configuration reads 00.
// - Variable rate off forces 48 kHz unless double rate is on; on enables rate registers.
// - Double rate doubles front DACs and powers down side converters.
// - Double rate without variable rate forces converters to 96 kHz.
// - Digital-output enable reads 1 only with the pulled-down strap.
// - Digital-output slot select picks pair 3/4, 7/8, 6/9 or 10/11.
// - Center, surround and LFE status bits read 1 when ready.
// - Digital-output config valid flags supported slot and rate combinations.
// - Side converter power-down bits stop them; status shows actual state.
// - Double rate slot select puts extra samples in 10/11 or 7/8.
`timescale 1ns/1ps
module cpr_regs (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic spdif_strap,
    output logic ext_amp_shutdown,
    output logic adc_off,
    output logic dac_off,
    output logic mixer_off,
    output logic reference_on,
    output logic bias_pins_on,
    output logic link_off,
    output logic clocks_stopped,
    output logic headphone_off,
    output logic center_off,
    output logic surround_off,
    output logic lfe_off,
    output logic spdif_tx_on,
    output logic rate_force_48k,
    output logic rate_force_96k,
    output logic rate_double,
    output logic [7:0] front_slots,
    output logic [7:0] surround_slots,
    output logic [7:0] center_lfe_slots,
    output logic [7:0] digital_out_slots,
    output logic [7:0] extra_sample_slots
);
    typedef struct packed {
        logic ack;
        logic [15:0] rdat;
        logic [15:8] pwr;
        logic [1:0] dac_slot_map;
        logic lfe_pd;
        logic sur_pd;
        logic cen_pd;
        logic [1:0] digital_out_slot_select;
        logic spdif_en;
        logic double_rate_enable;
        logic variable_rate_enable;
        logic mix_qual;
        logic [1:0] double_rate_slot_select;
        logic digital_out_rate_select;
        logic strap_s1;
        logic strap_s2;
        logic [1:0] strap_cnt;
        logic tx_present;
        logic [12:0] pins;
        logic [39:0] slots;
        logic [2:0] rate;
    } cpr_regs_s;

    cpr_regs_s s;
    cpr_regs_s next_s;
    logic [cpr_pkg::NSEC-1:0] want;
    logic [cpr_pkg::NSEC-1:0] sec_en;
    logic [cpr_pkg::NSEC-1:0] rdy;

    function automatic logic [7:0] cpr_pair(input logic [1:0] code);
        unique case (code)
            2'h0: cpr_pair = cpr_pkg::PAIR_0;
            2'h1: cpr_pair = cpr_pkg::PAIR_1;
            2'h2: cpr_pair = cpr_pkg::PAIR_2;
            2'h3: cpr_pair = cpr_pkg::PAIR_3;
        endcase
    endfunction

    function automatic logic [15:0] cpr_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
        cpr_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Each tracker models how long its subsection needs to reach nominal level.
    generate
        for (genvar i = 0; i < cpr_pkg::NSEC; i++) begin : g_sec
            cpr_settle #(
                .SETTLE_CYC(i == cpr_pkg::SEC_REF ? cpr_pkg::REF_SETTLE_CYC
                                                   : cpr_pkg::CONV_SETTLE_CYC)
            ) u_settle (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .enable(sec_en[i]),
                .ready(rdy[i])
            );
            // Converters only settle on top of a ready reference.
            assign sec_en[i] = (i == cpr_pkg::SEC_REF) ? want[i]
                                                       : want[i] & rdy[cpr_pkg::SEC_REF];
        end
    endgenerate

    logic mix_off;
    logic ref_run;
    logic side_c;
    logic side_s;
    logic side_l;
    logic clk_stop;
    logic cfg_ok;
    logic req;
    logic wr;
    logic [5:0] idx;
    logic [15:0] pwr_rd;
    logic [15:0] cap_rd;
    logic [15:0] ext_rd;
    logic [15:0] aux_rd;
    logic [15:0] wv;
    logic [7:0] xpair;

    always_comb begin
        mix_off = s.pwr[cpr_pkg::PWR_MIX] & ~s.mix_qual;
        // Any powered input path, output path or mixer holds the reference up.
        ref_run = ~s.pwr[cpr_pkg::PWR_IN] | ~s.pwr[cpr_pkg::PWR_OUT] | ~mix_off
                  | ~s.pwr[cpr_pkg::PWR_BIAS];
        side_c = s.cen_pd | s.double_rate_enable;
        side_s = s.sur_pd | s.double_rate_enable;
        side_l = s.lfe_pd | s.double_rate_enable;
        // The clock gate is refused while any converter or the link still runs.
        clk_stop = s.pwr[cpr_pkg::PWR_CLK] & s.pwr[cpr_pkg::PWR_IN] & s.pwr[cpr_pkg::PWR_OUT]
                   & s.pwr[cpr_pkg::PWR_LINK] & side_c & side_s & side_l;
        want = '0;
        want[cpr_pkg::SEC_ADC] = ~s.pwr[cpr_pkg::PWR_IN];
        want[cpr_pkg::SEC_DAC] = ~s.pwr[cpr_pkg::PWR_OUT];
        want[cpr_pkg::SEC_ANL] = ~mix_off;
        want[cpr_pkg::SEC_REF] = ref_run & ~s.pwr[cpr_pkg::PWR_BIAS];
        want[cpr_pkg::SEC_CEN] = ~side_c;
        want[cpr_pkg::SEC_SUR] = ~side_s;
        want[cpr_pkg::SEC_LFE] = ~side_l;
        xpair = s.double_rate_slot_select[1] ? cpr_pkg::PAIR_3 : (s.double_rate_slot_select[0] ? cpr_pkg::PAIR_1
                                                          : cpr_pkg::PAIR_3);
        // In double rate, digital out must not share the front or extra-sample pair, and must match
        // the fixed 48 kHz rate when rates are not variable.
        cfg_ok = (s.digital_out_rate_select | s.variable_rate_enable)
                 & ~(s.double_rate_enable & (s.digital_out_slot_select == s.dac_slot_map))
                 & ~(s.double_rate_enable & (cpr_pair(s.digital_out_slot_select) == xpair));
        req = cyc_i & stb_i;
        idx = adr_i[cpr_pkg::ADR_W-1:cpr_pkg::IDX_LSB];
        wr = req & we_i & s.ack;
        pwr_rd = {s.pwr, 4'h0, rdy[cpr_pkg::SEC_REF:cpr_pkg::SEC_ADC]};
        cap_rd = cpr_pkg::CAP_FIXED | {10'h000, s.dac_slot_map, 4'h0};
        ext_rd = '0;
        ext_rd[cpr_pkg::EXT_LFE_PD] = s.lfe_pd;
        ext_rd[cpr_pkg::EXT_SUR_PD] = s.sur_pd;
        ext_rd[cpr_pkg::EXT_CEN_PD] = s.cen_pd;
        ext_rd[cpr_pkg::EXT_CFG_OK] = cfg_ok;
        ext_rd[cpr_pkg::EXT_LFE_RDY] = rdy[cpr_pkg::SEC_LFE];
        ext_rd[cpr_pkg::EXT_SUR_RDY] = rdy[cpr_pkg::SEC_SUR];
        ext_rd[cpr_pkg::EXT_CEN_RDY] = rdy[cpr_pkg::SEC_CEN];
        ext_rd[cpr_pkg::EXT_DIGITAL_OUT_SLOT_SELECT+:2] = s.digital_out_slot_select;
        ext_rd[cpr_pkg::EXT_SPDIF] = s.spdif_en & s.tx_present;
        ext_rd[cpr_pkg::EXT_DRA] = s.double_rate_enable;
        ext_rd[cpr_pkg::EXT_VRA] = s.variable_rate_enable;
        aux_rd = '0;
        aux_rd[cpr_pkg::AUX_QUAL] = s.mix_qual;
        aux_rd[cpr_pkg::AUX_DOUBLE_RATE_SLOT_SELECT+:2] = s.double_rate_slot_select;
        aux_rd[cpr_pkg::AUX_DIGITAL_OUT_RATE_SELECT] = s.digital_out_rate_select;

        next_s = s;
        // One wait state: ack follows the request by one cycle and lasts one cycle.
        next_s.ack = req & ~s.ack;
        unique case (idx)
            cpr_pkg::IDX_PWR: next_s.rdat = pwr_rd;
            cpr_pkg::IDX_CAP: next_s.rdat = cap_rd;
            cpr_pkg::IDX_EXT: next_s.rdat = ext_rd;
            cpr_pkg::IDX_AUX: next_s.rdat = aux_rd;
            default: next_s.rdat = 16'h0000;
        endcase
        if (wr) begin
            unique case (idx)
                cpr_pkg::IDX_PWR: begin
                    wv = cpr_merge(pwr_rd, dat_i, sel_i);
                    next_s.pwr = wv[15:8];
                end
                cpr_pkg::IDX_CAP: begin
                    wv = cpr_merge(cap_rd, dat_i, sel_i);
                    next_s.dac_slot_map = wv[cpr_pkg::CAP_DSA+:2];
                end
                cpr_pkg::IDX_EXT: begin
                    wv = cpr_merge(ext_rd, dat_i, sel_i);
                    next_s.lfe_pd = wv[cpr_pkg::EXT_LFE_PD];
                    next_s.sur_pd = wv[cpr_pkg::EXT_SUR_PD];
                    next_s.cen_pd = wv[cpr_pkg::EXT_CEN_PD];
                    next_s.digital_out_slot_select = wv[cpr_pkg::EXT_DIGITAL_OUT_SLOT_SELECT+:2];
                    next_s.spdif_en = wv[cpr_pkg::EXT_SPDIF];
                    next_s.double_rate_enable = wv[cpr_pkg::EXT_DRA];
                    next_s.variable_rate_enable = wv[cpr_pkg::EXT_VRA];
                end
                cpr_pkg::IDX_AUX: begin
                    wv = cpr_merge(aux_rd, dat_i, sel_i);
                    next_s.mix_qual = wv[cpr_pkg::AUX_QUAL];
                    next_s.double_rate_slot_select = wv[cpr_pkg::AUX_DOUBLE_RATE_SLOT_SELECT+:2];
                    next_s.digital_out_rate_select = wv[cpr_pkg::AUX_DIGITAL_OUT_RATE_SELECT];
                end
                default: wv = 16'h0000;
            endcase
        end else begin
            wv = 16'h0000;
        end

        // The strap is caught once, after the synchroniser has filled past reset.
        next_s.strap_s1 = spdif_strap;
        next_s.strap_s2 = s.strap_s1;
        // The second stage only holds the pin level from the second edge after release.
        if (s.strap_cnt != cpr_pkg::STRAP_WAIT + 2'h1) begin
            next_s.strap_cnt = s.strap_cnt + 2'h1;
        end
        if (s.strap_cnt == cpr_pkg::STRAP_WAIT) begin
            next_s.tx_present = ~s.strap_s2;
        end

        next_s.pins = {s.pwr[cpr_pkg::PWR_EXTERNAL_AMP_SHUTDOWN],
                       s.pwr[cpr_pkg::PWR_IN],
                       s.pwr[cpr_pkg::PWR_OUT],
                       mix_off,
                       ref_run,
                       ~s.pwr[cpr_pkg::PWR_BIAS],
                       s.pwr[cpr_pkg::PWR_LINK],
                       clk_stop,
                       s.pwr[cpr_pkg::PWR_HP],
                       side_c, side_s, side_l,
                       s.spdif_en & s.tx_present};
        next_s.slots = {cpr_pair(s.dac_slot_map),
                        cpr_pair(s.dac_slot_map + 2'h1),
                        cpr_pair(s.dac_slot_map + 2'h2),
                        cpr_pair(s.digital_out_slot_select),
                        xpair};
        next_s.rate = {s.double_rate_enable, s.double_rate_enable & ~s.variable_rate_enable, ~s.variable_rate_enable & ~s.double_rate_enable};
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.digital_out_rate_select <= cpr_pkg::AUX_DIGITAL_OUT_RATE_SELECT_RST;
            s.strap_s1 <= 1'b1;
            s.strap_s2 <= 1'b1;
            s.rate <= 3'h1;
        end else begin
            s <= next_s;
        end
    end

    assign ack_o = s.ack;
    assign dat_o = {16'h0000, s.rdat};
    assign ext_amp_shutdown = s.pins[12];
    assign adc_off = s.pins[11];
    assign dac_off = s.pins[10];
    assign mixer_off = s.pins[9];
    assign reference_on = s.pins[8];
    assign bias_pins_on = s.pins[7];
    assign link_off = s.pins[6];
    assign clocks_stopped = s.pins[5];
    assign headphone_off = s.pins[4];
    assign center_off = s.pins[3];
    assign surround_off = s.pins[2];
    assign lfe_off = s.pins[1];
    assign spdif_tx_on = s.pins[0];
    assign rate_double = s.rate[2];
    assign rate_force_96k = s.rate[1];
    assign rate_force_48k = s.rate[0];
    assign front_slots = s.slots[39:32];
    assign surround_slots = s.slots[31:24];
    assign center_lfe_slots = s.slots[23:16];
    assign digital_out_slots = s.slots[15:8];
    assign extra_sample_slots = s.slots[7:0];

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence bus_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence pwr_write_s;
        cyc_i && stb_i && we_i && ack_o && idx == cpr_pkg::IDX_PWR && sel_i[1];
    endsequence

    bus_ack_a: assert property (bus_req_s |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single pulse after request");
    // A write that keeps the controls and writes zeros to the ready bits must not clear them.
    ready_ro_a: assert property ((pwr_write_s and dat_i[3:0] == 4'h0
        and dat_i[cpr_pkg::PWR_EXTERNAL_AMP_SHUTDOWN:cpr_pkg::PWR_IN] == s.pwr)
        |=> (rdy[3:0] & $past(rdy[3:0])) == $past(rdy[3:0]))
        else $error("write cleared a ready bit");
    ready_read_a: assert property (ack_o && !we_i && $past(idx) == cpr_pkg::IDX_PWR |->
        dat_o[3:0] == $past(rdy[3:0])) else $error("ready status read wrong");
    amp_pin_a: assert property (pwr_write_s |=> ##1
        ext_amp_shutdown == $past(dat_i[cpr_pkg::PWR_EXTERNAL_AMP_SHUTDOWN], 2))
        else $error("amp shutdown pin not following write");
    clk_gate_a: assert property (clocks_stopped |-> $past(s.pwr[cpr_pkg::PWR_IN]
        && s.pwr[cpr_pkg::PWR_OUT] && s.pwr[cpr_pkg::PWR_LINK]))
        else $error("clocks stopped with converters running");
    rate_96k_a: assert property (s.double_rate_enable && !s.variable_rate_enable |=> rate_force_96k && !rate_force_48k)
        else $error("96 kHz not forced");
    side_down_a: assert property (s.double_rate_enable |=> center_off && surround_off && lfe_off)
        else $error("side converters on in double rate");
    ready_wait_a: assert property ($rose(sec_en[cpr_pkg::SEC_ADC]) |=>
        !rdy[cpr_pkg::SEC_ADC] [*8]) else $error("ADC ready before settling");
    tx_strap_a: assert property (spdif_tx_on |-> $past(s.tx_present))
        else $error("transmitter on without strap");
    cap_read_a: assert property (ack_o && !we_i && $past(idx) == cpr_pkg::IDX_CAP |->
        dat_o[15:0] == (cpr_pkg::CAP_FIXED | {10'h000, $past(s.dac_slot_map), 4'h0}))
        else $error("capability value wrong");
endmodule

//--- core/cpr_settle.sv
// Power-up settling tracker for one subsection.
`timescale 1ns/1ps
module cpr_settle #(
    parameter logic [7:0] SETTLE_CYC = 8'h01
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic enable,
    output logic ready
);
    typedef struct packed {
        logic [7:0] cnt;
        logic ready;
    } cpr_settle_s;

    cpr_settle_s s;
    cpr_settle_s next_s;

    // Ready drops at once on power-down but rises only after the full settle count.
    always_comb begin
        next_s = s;
        if (!enable) begin
            next_s.cnt = 8'h00;
            next_s.ready = 1'b0;
        end else if (s.cnt == SETTLE_CYC - 8'h01) begin
            next_s.ready = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ready = s.ready;

    settle_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !enable |=> !ready) else $error("ready stayed up after power-down");
endmodule

//--- shared/cpr_pkg.sv
// Constants for the codec power-down and extended audio register bank.
package cpr_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [5:0] IDX_PWR = 6'h26;
    localparam logic [5:0] IDX_CAP = 6'h28;
    localparam logic [5:0] IDX_EXT = 6'h2A;
    localparam logic [5:0] IDX_AUX = 6'h3C;
    localparam int ADR_W = 8;
    localparam int IDX_LSB = 2;

    // Power-down register fields.
    localparam int PWR_EXTERNAL_AMP_SHUTDOWN = 15;
    localparam int PWR_HP = 14;
    localparam int PWR_CLK = 13;
    localparam int PWR_LINK = 12;
    localparam int PWR_BIAS = 11;
    localparam int PWR_MIX = 10;
    localparam int PWR_OUT = 9;
    localparam int PWR_IN = 8;

    // Capability register: fixed bits plus the writable slot map field.
    localparam logic [15:0] CAP_FIXED = 16'h0BC7;
    localparam int CAP_DSA = 4;

    // Extended status/control fields.
    localparam int EXT_LFE_PD = 13;
    localparam int EXT_SUR_PD = 12;
    localparam int EXT_CEN_PD = 11;
    localparam int EXT_CFG_OK = 10;
    localparam int EXT_LFE_RDY = 8;
    localparam int EXT_SUR_RDY = 7;
    localparam int EXT_CEN_RDY = 6;
    localparam int EXT_DIGITAL_OUT_SLOT_SELECT = 4;
    localparam int EXT_SPDIF = 2;
    localparam int EXT_DRA = 1;
    localparam int EXT_VRA = 0;

    // Auxiliary control fields.
    localparam int AUX_QUAL = 0;
    localparam int AUX_DOUBLE_RATE_SLOT_SELECT = 1;
    localparam int AUX_DIGITAL_OUT_RATE_SELECT = 3;
    localparam logic AUX_DIGITAL_OUT_RATE_SELECT_RST = 1'b1;

    // Subsection indices of the ready trackers.
    localparam int SEC_ADC = 0;
    localparam int SEC_DAC = 1;
    localparam int SEC_ANL = 2;
    localparam int SEC_REF = 3;
    localparam int SEC_CEN = 4;
    localparam int SEC_SUR = 5;
    localparam int SEC_LFE = 6;
    localparam int NSEC = 7;

    // Slot pairs, left slot in the high nibble.
    localparam logic [7:0] PAIR_0 = 8'h34;
    localparam logic [7:0] PAIR_1 = 8'h78;
    localparam logic [7:0] PAIR_2 = 8'h69;
    localparam logic [7:0] PAIR_3 = 8'hAB;

    // Settling times and their cycle counts at the system clock rate.
    localparam int CLK_MHZ = 100;
    localparam int REF_SETTLE_NS = 2000;
    localparam int CONV_SETTLE_NS = 500;
    localparam logic [7:0] REF_SETTLE_CYC = 8'((REF_SETTLE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] CONV_SETTLE_CYC = 8'((CONV_SETTLE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage

//--- tb/cpr_host.sv
// Bus master model of the link controller that owns the register bus.
`timescale 1ns/1ps
module cpr_host (
    input wire logic clk_sys,
    input wire logic ack,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [3:0] sel,
    output logic [7:0] adr,
    output logic [31:0] wdat,
    output logic hung
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 8'h00;
        wdat = 32'h0000_0000;
        hung = 1'b0;
    end

    // Released lines carry inverted values so that a slave relying on stale
    // address or data after the cycle shows up as a wrong register value.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 64);
        q = rdat[15:0];
        hung = (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= ~w;
        adr <= ~a;
        wdat <= ~wdat;
        @(posedge clk_sys);
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the codec power and extended audio registers.
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] A_PWR = {cpr_pkg::IDX_PWR, 2'b00};
    localparam logic [7:0] A_CAP = {cpr_pkg::IDX_CAP, 2'b00};
    localparam logic [7:0] A_EXT = {cpr_pkg::IDX_EXT, 2'b00};
    localparam logic [7:0] A_AUX = {cpr_pkg::IDX_AUX, 2'b00};
    localparam logic [7:0] PR[4] = '{8'h34, 8'h78, 8'h69, 8'hAB};
    logic clk_sys, rst_b, spdif_strap, we, cyc, stb, ack, hung;
    logic [3:0] sel;
    logic [7:0] adr, fs, ss, cs, ds, xs;
    logic [31:0] wdat, rdat;
    logic amp, adc, dac, mix, rf, bias, lnk, cst, hp, cen, sur, lfe, tx, r48, r96, rd2;
    logic [15:0] q;
    int n_mismatch = 0;
    int cmp_count = 0;
    wire [15:0] lv = {amp, adc, dac, mix, rf, bias, lnk, cst, hp, cen, sur, lfe, tx, r48, r96, rd2};

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    cpr_host u_host (.clk_sys(clk_sys), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
        .we(we), .sel(sel), .adr(adr), .wdat(wdat), .hung(hung));

    cpr_regs u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
        .spdif_strap(spdif_strap), .ext_amp_shutdown(amp), .adc_off(adc), .dac_off(dac),
        .mixer_off(mix), .reference_on(rf), .bias_pins_on(bias), .link_off(lnk),
        .clocks_stopped(cst), .headphone_off(hp), .center_off(cen), .surround_off(sur),
        .lfe_off(lfe), .spdif_tx_on(tx), .rate_force_48k(r48), .rate_force_96k(r96),
        .rate_double(rd2), .front_slots(fs), .surround_slots(ss), .center_lfe_slots(cs),
        .digital_out_slots(ds), .extra_sample_slots(xs));

    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        u_host.xfer(w, a, d, q);
        if (hung) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            results();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(q & m, e, "register read");
    endtask

    // Output pins follow a write two edges later, so four edges is ample.
    task automatic lvchk(input logic [15:0] e);
        repeat (4) @(posedge clk_sys);
        chk(lv, e, "output levels");
    endtask

    task automatic wait_rdy(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 16'h0000);
            n++;
        end while ((q & m) !== e && n < 300);
        chk(q & m, e, "status settle");
    endtask

    task automatic t_reset();
        lvchk(16'h0C04);
        rdc(A_CAP, 16'hFFFF, 16'h0BC7);
        rdc(A_CAP, 16'hCC00, 16'h0800);
        rdc(A_AUX, 16'hFFFF, 16'h0008);
        wait_rdy(A_PWR, 16'hFFFF, 16'h000F);
        wait_rdy(A_EXT, 16'hFFFF, 16'h05C0);
    endtask

    task automatic t_readonly();
        bus(1'b1, A_PWR, 16'h00F0);
        rdc(A_PWR, 16'hFFFF, 16'h000F);
        bus(1'b1, A_PWR, 16'h000F);
        rdc(A_PWR, 16'hFFFF, 16'h000F);
        bus(1'b1, A_CAP, 16'hFFCF);
        rdc(A_CAP, 16'hFFFF, 16'h0BC7);
        bus(1'b1, 8'h40, 16'hFFFF);
        rdc(8'h40, 16'hFFFF, 16'h0000);
    endtask

    task automatic t_power();
        bus(1'b1, A_PWR, 16'h8000);
        lvchk(16'h8C04);
        bus(1'b1, A_PWR, 16'h0100);
        lvchk(16'h4C04);
        wait_rdy(A_PWR, 16'hFFFF, 16'h010E);
        bus(1'b1, A_PWR, 16'h0200);
        lvchk(16'h2C04);
        wait_rdy(A_PWR, 16'hFFFF, 16'h020D);
        bus(1'b1, A_PWR, 16'h0E00);
        lvchk(16'h3804);
        bus(1'b1, A_PWR, 16'h0F00);
        lvchk(16'h7004);
        wait_rdy(A_PWR, 16'h0008, 16'h0000);
        bus(1'b1, A_PWR, 16'h0800);
        lvchk(16'h0804);
        bus(1'b1, A_PWR, 16'h4400);
        lvchk(16'h1C84);
        bus(1'b1, A_AUX, 16'h0009);
        lvchk(16'h0C84);
        bus(1'b1, A_AUX, 16'h0008);
        bus(1'b1, A_PWR, 16'h0000);
        wait_rdy(A_PWR, 16'hFFFF, 16'h000F);
    endtask

    // Power-up sequences are complete here before link and clocks go down.
    task automatic t_clocks();
        bus(1'b1, A_PWR, 16'h2000);
        lvchk(16'h0C04);
        bus(1'b1, A_EXT, 16'h3800);
        bus(1'b1, A_PWR, 16'h3300);
        lvchk(16'h6F74);
        bus(1'b1, A_PWR, 16'h1300);
        lvchk(16'h6E74);
        bus(1'b1, A_PWR, 16'h0000);
        bus(1'b1, A_EXT, 16'h0800);
        lvchk(16'h0C44);
        wait_rdy(A_EXT, 16'h01C0, 16'h0180);
        bus(1'b1, A_EXT, 16'h3000);
        lvchk(16'h0C34);
        wait_rdy(A_EXT, 16'h01C0, 16'h0040);
        bus(1'b1, A_EXT, 16'h0000);
        wait_rdy(A_EXT, 16'h01C0, 16'h01C0);
    endtask

    task automatic t_rates();
        bus(1'b1, A_EXT, 16'h0001);
        lvchk(16'h0C00);
        bus(1'b1, A_EXT, 16'h0002);
        lvchk(16'h0C73);
        rdc(A_EXT, 16'h0400, 16'h0000);
        bus(1'b1, A_EXT, 16'h0003);
        lvchk(16'h0C71);
        bus(1'b1, A_EXT, 16'h0000);
        bus(1'b1, A_AUX, 16'h0000);
        rdc(A_EXT, 16'h0400, 16'h0000);
        bus(1'b1, A_AUX, 16'h0008);
        rdc(A_EXT, 16'h0400, 16'h0400);
        bus(1'b1, A_EXT, 16'h0004);
        lvchk(16'h0C0C);
        rdc(A_EXT, 16'h0004, 16'h0004);
        bus(1'b1, A_EXT, 16'h0000);
    endtask

    task automatic t_slots();
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, A_CAP, 16'(i << 4));
            bus(1'b1, A_EXT, 16'(i << 4));
            bus(1'b1, A_AUX, 16'h0008 | 16'(i << 1));
            lvchk(16'h0C04);
            chk({fs, ss}, {PR[i], PR[(i + 1) % 4]}, "front surround");
            chk({cs, ds}, {PR[(i + 2) % 4], PR[i]}, "c-lfe digital");
            chk({8'h00, xs}, {8'h00, (i == 1) ? 8'h78 : 8'hAB}, "extra");
            rdc(A_CAP, 16'hFFFF, 16'h0BC7 | 16'(i << 4));
        end
    endtask

    // A second reset with the strap pulled high: the transmitter must read as absent.
    task automatic t_strap();
        @(posedge clk_sys);
        spdif_strap <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        bus(1'b1, A_EXT, 16'h0004);
        lvchk(16'h0C04);
        rdc(A_EXT, 16'h0004, 16'h0000);
    endtask

    initial begin
        rst_b = 1'b0;
        spdif_strap = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_readonly();
        t_power();
        t_clocks();
        t_rates();
        t_slots();
        t_strap();
        results();
    end
endmodule
